// File: pkg/bus_match_pkg.sv
package bus_match_pkg;

  // ==========================================
  // widths and counts
  localparam int LW_W = 36;
  localparam int WORD_W = 18;
  localparam int BYTE_W = 9;
  localparam int FIFO_DEPTH = 4;
  localparam logic [1:0] WORD_LAST = 2'h1;
  localparam logic [1:0] BYTE_LAST = 2'h3;
  localparam int SYNC_N = 7;

  // ==========================================
  // synchroniser bit positions
  localparam int SY_ENDIAN = 0;
  localparam int SY_TX_BYTE = 1;
  localparam int SY_RX_BYTE = 2;
  localparam int SY_FIFO_ONE_MASTER_RESET_N = 3;
  localparam int SY_FIFO_TWO_MASTER_RESET_N = 4;
  localparam int SY_FIFO_ONE_PARTIAL_RESET_N = 5;
  localparam int SY_FIFO_TWO_PARTIAL_RESET_N = 6;

  // ==========================================
  // reset values
  localparam logic [SYNC_N-1:0] SYNC_RST = 7'h78;
  localparam logic [LW_W-1:0] LW_RST = 36'h0;
  localparam logic [WORD_W-1:0] WORD_RST = 18'h0;
  localparam logic [1:0] MRS_PREV_RST = 2'h3;

  // ==========================================
  // carriers
  typedef struct packed {
    logic tx_byte;
    logic rx_byte;
    logic big_endian;
  } cfg_type;

  localparam cfg_type CFG_RST = '{tx_byte: 1'b0, rx_byte: 1'b0,
                                  big_endian: 1'b0};

  typedef struct packed {
    logic [SYNC_N-1:0] syn1;
    logic [SYNC_N-1:0] syn2;
    logic [1:0] mrs_prev;
    cfg_type cfg;
    logic [LW_W-1:0] tx_hold;
    logic [1:0] tx_idx;
    logic tx_have;
    logic lw_in_ready;
    logic [WORD_W-1:0] tx_data;
    logic [LW_W-1:0] rx_acc;
    logic [1:0] rx_idx;
    logic pend;
    logic [LW_W-1:0] pend_lw;
    logic rx_ready;
    logic [WORD_W-1:0] mail;
    logic mail_valid;
  } state_type;

endpackage

// File: verilog/fifo_bus_width_matcher.sv
`timescale 1ns/1ps

// ==========================================
// small flop fifo
module lw_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic clear,
  // fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic [WIDTH-1:0] head;
    logic vld;
  } fifo_state_type;

  fifo_state_type st_r;
  fifo_state_type st_nxt;
  logic push;
  logic pop;

  assign in_ready = (st_r.cnt != FULL_CNT);
  assign out_valid = st_r.vld;
  assign out_data = st_r.head;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = (st_r.wp == LAST_PTR) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == LAST_PTR) ? '0 : st_r.rp + 1'b1;
    end
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
    if (clear) begin
      st_nxt.wp = '0;
      st_nxt.rp = '0;
      st_nxt.cnt = '0;
    end
    // head and valid kept in flops
    st_nxt.vld = (st_nxt.cnt != '0);
    st_nxt.head = st_nxt.mem[st_nxt.rp];
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ==========================================
// bus width matcher
// Overview of operation
// - fetch whole long words, show first portion
// - each read advances portion; then fetch next
// - byte transmit uses low nine lines only
// - receive stores only complete long words
// - last byte or word commits long word
// - byte receive ignores upper nine inputs
// - receive word lane order follows endian
// - receive byte lane order follows endian
// - transmit word lane order follows endian
// - transmit byte lane order follows endian
// - endian fixed at reset; widths also set at reset
// - endian sampled on master reset release
// - mailbox data bypasses endian reordering
module fifo_bus_width_matcher (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // configuration pins
  input wire logic tx_port_width_select,
  input wire logic rx_port_width_select,
  input wire logic endian_order_select,
  input wire logic fifo_one_master_reset_n,
  input wire logic fifo_two_master_reset_n,
  input wire logic fifo_one_partial_reset_n,
  input wire logic fifo_two_partial_reset_n,
  // long words from the first fifo
  input wire logic [bus_match_pkg::LW_W-1:0] lw_in_data,
  input wire logic lw_in_valid,
  output logic lw_in_ready,
  // transmit port
  input wire logic tx_read,
  output logic [bus_match_pkg::WORD_W-1:0] tx_data,
  output logic tx_valid,
  // receive port
  input wire logic rx_write,
  input wire logic [bus_match_pkg::WORD_W-1:0] rx_data,
  input wire logic rx_port_mailbox_select,
  output logic rx_ready,
  // mailbox bypass
  output logic [bus_match_pkg::WORD_W-1:0] mail_data,
  output logic mail_valid,
  // long words to the second fifo
  output logic [bus_match_pkg::LW_W-1:0] lw_out_data,
  output logic lw_out_valid,
  input wire logic lw_out_ready
);

  // ==========================================
  // state
  bus_match_pkg::state_type st_r;
  bus_match_pkg::state_type st_nxt;
  logic fifo_in_ready;
  logic [bus_match_pkg::SYNC_N-1:0] pins;
  logic fifo_one_master_reset_n_s;
  logic fifo_two_master_reset_n_s;
  logic clear_tx;
  logic clear_rx;

  assign pins = {fifo_two_partial_reset_n, fifo_one_partial_reset_n,
                 fifo_two_master_reset_n, fifo_one_master_reset_n,
                 rx_port_width_select, tx_port_width_select,
                 endian_order_select};
  assign fifo_one_master_reset_n_s = st_r.syn2[bus_match_pkg::SY_FIFO_ONE_MASTER_RESET_N];
  assign fifo_two_master_reset_n_s = st_r.syn2[bus_match_pkg::SY_FIFO_TWO_MASTER_RESET_N];
  // partial reset clears data only, config is kept
  assign clear_tx = ~fifo_one_master_reset_n_s | ~st_r.syn2[bus_match_pkg::SY_FIFO_ONE_PARTIAL_RESET_N];
  assign clear_rx = ~fifo_two_master_reset_n_s | ~st_r.syn2[bus_match_pkg::SY_FIFO_TWO_PARTIAL_RESET_N];

  // ==========================================
  // lane helpers
  function automatic logic [1:0] lane_pos(input logic [1:0] idx,
                                          input logic byte_mode,
                                          input logic big);
    logic [1:0] last;
    last = byte_mode ? bus_match_pkg::BYTE_LAST : bus_match_pkg::WORD_LAST;
    lane_pos = big ? (last - idx) : idx;
  endfunction

  function automatic logic [bus_match_pkg::WORD_W-1:0] pick(
      input logic [bus_match_pkg::LW_W-1:0] lw,
      input logic [1:0] pos,
      input logic byte_mode);
    if (byte_mode) begin
      // upper nine lines driven low
      pick = {9'h000, lw[pos*bus_match_pkg::BYTE_W +: 9]};
    end else begin
      pick = lw[pos[0]*bus_match_pkg::WORD_W +: 18];
    end
  endfunction

  function automatic logic [bus_match_pkg::LW_W-1:0] place(
      input logic [bus_match_pkg::LW_W-1:0] lw,
      input logic [bus_match_pkg::WORD_W-1:0] d,
      input logic [1:0] pos,
      input logic byte_mode);
    logic [bus_match_pkg::LW_W-1:0] r;
    r = lw;
    if (byte_mode) begin
      r[pos*bus_match_pkg::BYTE_W +: 9] = d[8:0];
    end else begin
      r[pos[0]*bus_match_pkg::WORD_W +: 18] = d;
    end
    place = r;
  endfunction

  // ==========================================
  // next state
  always_comb begin
    logic [1:0] pos;
    logic [1:0] last;
    pos = 2'h0;
    last = 2'h0;
    st_nxt = st_r;
    st_nxt.syn1 = pins;
    st_nxt.syn2 = st_r.syn1;
    st_nxt.mrs_prev = {fifo_two_master_reset_n_s, fifo_one_master_reset_n_s};
    st_nxt.mail_valid = 1'b0;

    // endian and widths caught as master reset is released
    if ((fifo_one_master_reset_n_s && !st_r.mrs_prev[0]) || (fifo_two_master_reset_n_s && !st_r.mrs_prev[1])) begin
      st_nxt.cfg.big_endian = st_r.syn2[bus_match_pkg::SY_ENDIAN];
      // high selects byte width on both ports
      st_nxt.cfg.tx_byte = st_r.syn2[bus_match_pkg::SY_TX_BYTE];
      st_nxt.cfg.rx_byte = st_r.syn2[bus_match_pkg::SY_RX_BYTE];
    end

    // transmit side
    last = st_r.cfg.tx_byte ? bus_match_pkg::BYTE_LAST
                            : bus_match_pkg::WORD_LAST;
    if (!st_r.tx_have) begin
      if (lw_in_valid && st_r.lw_in_ready) begin
        st_nxt.tx_hold = lw_in_data;
        st_nxt.tx_idx = 2'h0;
        st_nxt.tx_have = 1'b1;
        pos = lane_pos(2'h0, st_r.cfg.tx_byte, st_r.cfg.big_endian);
        st_nxt.tx_data = pick(lw_in_data, pos, st_r.cfg.tx_byte);
      end
    end else if (tx_read) begin
      if (st_r.tx_idx == last) begin
        st_nxt.tx_have = 1'b0;
      end else begin
        st_nxt.tx_idx = st_r.tx_idx + 2'h1;
        pos = lane_pos(st_r.tx_idx + 2'h1, st_r.cfg.tx_byte,
                       st_r.cfg.big_endian);
        st_nxt.tx_data = pick(st_r.tx_hold, pos, st_r.cfg.tx_byte);
      end
    end
    if (clear_tx) begin
      st_nxt.tx_have = 1'b0;
      st_nxt.tx_idx = 2'h0;
    end
    // ready stays low while a fifo one master or partial reset is held
    st_nxt.lw_in_ready = ~st_nxt.tx_have & ~clear_tx;

    // receive side
    last = st_r.cfg.rx_byte ? bus_match_pkg::BYTE_LAST
                            : bus_match_pkg::WORD_LAST;
    if (st_r.pend && fifo_in_ready) begin
      st_nxt.pend = 1'b0;
    end
    if (rx_write && st_r.rx_ready) begin
      if (rx_port_mailbox_select) begin
        // mailbox keeps port order, no lane swapping
        st_nxt.mail = st_r.cfg.rx_byte ? {9'h000, rx_data[8:0]}
                                       : rx_data;
        st_nxt.mail_valid = 1'b1;
      end else begin
        pos = lane_pos(st_r.rx_idx, st_r.cfg.rx_byte, st_r.cfg.big_endian);
        // earlier parts wait in the accumulator
        st_nxt.rx_acc = place(st_r.rx_acc, rx_data, pos,
                              st_r.cfg.rx_byte);
        if (st_r.rx_idx == last) begin
          // whole long word goes to memory on the last part
          st_nxt.pend_lw = place(st_r.rx_acc, rx_data, pos,
                                 st_r.cfg.rx_byte);
          st_nxt.pend = 1'b1;
          st_nxt.rx_idx = 2'h0;
        end else begin
          st_nxt.rx_idx = st_r.rx_idx + 2'h1;
        end
      end
    end
    if (clear_rx) begin
      st_nxt.pend = 1'b0;
      st_nxt.rx_idx = 2'h0;
    end
    // back-pressure from the fifo stalls the receive port
    st_nxt.rx_ready = ~st_nxt.pend & ~clear_rx;
  end

  // ==========================================
  // registers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.syn1 <= bus_match_pkg::SYNC_RST;
      st_r.syn2 <= bus_match_pkg::SYNC_RST;
      st_r.mrs_prev <= bus_match_pkg::MRS_PREV_RST;
      st_r.cfg <= bus_match_pkg::CFG_RST;
      st_r.tx_hold <= bus_match_pkg::LW_RST;
      st_r.tx_data <= bus_match_pkg::WORD_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // receive fifo
  lw_fifo #(
    .WIDTH(bus_match_pkg::LW_W),
    .DEPTH(bus_match_pkg::FIFO_DEPTH)
  ) rx_fifo (
    .clock(clock),
    .rstn(rstn),
    .clear(clear_rx),
    .in_data(st_r.pend_lw),
    .in_valid(st_r.pend),
    .in_ready(fifo_in_ready),
    .out_data(lw_out_data),
    .out_valid(lw_out_valid),
    .out_ready(lw_out_ready)
  );

  // ==========================================
  // outputs
  assign lw_in_ready = st_r.lw_in_ready;
  assign tx_data = st_r.tx_data;
  assign tx_valid = st_r.tx_have;
  assign rx_ready = st_r.rx_ready;
  assign mail_data = st_r.mail;
  assign mail_valid = st_r.mail_valid;
endmodule

// File: test/bus_match_assertions.sv
`timescale 1ns/1ps

// ==========================================
// port checker
module bus_match_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // pins
  input wire logic tx_port_width_select,
  input wire logic rx_port_width_select,
  input wire logic endian_order_select,
  // long words in
  input wire logic [bus_match_pkg::LW_W-1:0] lw_in_data,
  input wire logic lw_in_valid,
  input wire logic lw_in_ready,
  // transmit port
  input wire logic tx_read,
  input wire logic [bus_match_pkg::WORD_W-1:0] tx_data,
  input wire logic tx_valid,
  // receive port
  input wire logic rx_write,
  input wire logic [bus_match_pkg::WORD_W-1:0] rx_data,
  input wire logic rx_port_mailbox_select,
  input wire logic rx_ready,
  // mailbox and long words out
  input wire logic [bus_match_pkg::WORD_W-1:0] mail_data,
  input wire logic mail_valid,
  input wire logic [bus_match_pkg::LW_W-1:0] lw_out_data,
  input wire logic lw_out_valid,
  input wire logic lw_out_ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic take, mail_in;
  logic [17:0] hi_in;
  logic [8:0] lo_in;
  assign take = lw_in_valid && lw_in_ready;
  assign mail_in = rx_write && rx_ready && rx_port_mailbox_select;
  assign hi_in = lw_in_data[35:18];
  assign lo_in = lw_in_data[8:0];

  // ==========================================
  // assertions
  chk_take_shows: assert property (take |=> tx_valid && !lw_in_ready)
    else $error("taken long word not shown");
  chk_no_early: assert property (tx_valid |-> !lw_in_ready)
    else $error("fetch before portions done");
  chk_portion_holds: assert property (
    tx_valid && !tx_read |=> tx_valid && $stable(tx_data))
    else $error("portion changed without read");
  chk_first_big: assert property (take && endian_order_select &&
    !tx_port_width_select |=> tx_data == $past(hi_in))
    else $error("first word wrong");
  chk_first_low: assert property (take && !endian_order_select &&
    tx_port_width_select |=> tx_data[8:0] == $past(lo_in))
    else $error("first byte wrong");
  chk_byte_upper: assert property (
    tx_valid && tx_port_width_select |-> tx_data[17:9] == 9'h0)
    else $error("upper lines driven");
  chk_commit_gap: assert property (
    $rose(lw_out_valid) |-> !$past(rx_ready))
    else $error("entry without commit");
  chk_out_holds: assert property (
    lw_out_valid && !lw_out_ready |=> lw_out_valid && $stable(lw_out_data))
    else $error("head lost");
  chk_mail_pass: assert property (mail_in |=> mail_valid &&
    (rx_port_width_select || mail_data == $past(rx_data)))
    else $error("mailbox word wrong");
  cover property (!rx_ready && lw_out_valid && !lw_out_ready);
  cover property (mail_in);
  cover property (tx_read && tx_valid ##1 tx_read && tx_valid);
endmodule

bind fifo_bus_width_matcher bus_match_checker u_chk (.clock, .rstn,
  .tx_port_width_select, .rx_port_width_select, .endian_order_select,
  .lw_in_data, .lw_in_valid, .lw_in_ready, .tx_read, .tx_data, .tx_valid,
  .rx_write, .rx_data, .rx_port_mailbox_select, .rx_ready, .mail_data,
  .mail_valid, .lw_out_data, .lw_out_valid, .lw_out_ready);

// File: test/tx_port_reader.sv
`timescale 1ns/1ps

// ==========================================
// transmit port reader
module tx_port_reader (
  // clock
  input wire logic clock,
  // transmit port
  input wire logic tx_valid,
  input wire logic [bus_match_pkg::WORD_W-1:0] tx_data,
  output logic tx_read,
  // pacing
  input wire logic slow
);
  logic [bus_match_pkg::WORD_W-1:0] got[$];
  initial tx_read = 1'h0;
  always @(posedge clock) begin
    if (tx_read && tx_valid)
      got.push_back(tx_data);
    tx_read <= tx_valid && !(slow && tx_read);
  end
endmodule

// File: test/tb.sv
`timescale 1ns/1ps

// ==========================================
// bench top
module tb;
  logic clock = 1'h0, rstn = 1'h0, endian_order_select = 1'h0;
  logic tx_port_width_select = 1'h0, rx_port_width_select = 1'h0;
  logic fifo_one_master_reset_n = 1'h0, fifo_two_master_reset_n = 1'h0;
  logic fifo_one_partial_reset_n = 1'h1, fifo_two_partial_reset_n = 1'h1;
  logic rx_port_mailbox_select = 1'h1, lw_in_valid = 1'h0;
  logic rx_write = 1'h0, lw_out_ready = 1'h0, slow = 1'h0;
  logic [35:0] lw_in_data = 36'h0;
  logic [17:0] rx_data = 18'h0;
  logic lw_in_ready, tx_read, tx_valid, rx_ready, mail_valid, lw_out_valid;
  logic [17:0] tx_data, mail_data;
  logic [35:0] lw_out_data;
  logic [35:0] lw_q[$];
  int err_total = 0, n_tests = 0;
  wire [2:0] flags = {lw_out_valid, lw_in_ready, rx_ready};

  always #10 clock = ~clock;

  fifo_bus_width_matcher u_dut (.*);
  tx_port_reader u_far (.clock, .tx_valid, .tx_data, .tx_read, .slow);

  // ==========================================
  // helpers
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cmp(input logic [35:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s %h vs %h", $time, m, got, exp);
    end
  endtask

  task automatic wait_on(input int k);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (flags[k] !== 1'h1 && n < 60);
    if (flags[k] !== 1'h1) begin
      err_total++;
      $display("wrong value at %0t: timeout", $time);
      tally_and_finish();
    end
  endtask

  function automatic logic [17:0] part(input logic [35:0] w, input int i,
                                       input logic b, input logic e);
    int k;
    k = e ? (b ? 3 : 1) - i : i;
    return b ? {9'h0, w[k*9 +: 9]} : w[k*18 +: 18];
  endfunction

  task automatic put(input logic [17:0] d, input logic mb);
    rx_write <= 1'h1;
    rx_data <= d;
    rx_port_mailbox_select <= mb;
    wait_on(0);
  endtask

  task automatic run(input logic b, input logic e);
    int np;
    logic [17:0] m;
    np = b ? 4 : 2;
    m = 18'h2b3c5 & (b ? 18'h1ff : 18'h3ffff);
    tx_port_width_select <= b;
    rx_port_width_select <= b;
    endian_order_select <= e;
    slow <= e;
    fifo_one_master_reset_n <= 1'h0;
    fifo_two_master_reset_n <= 1'h0;
    rx_port_mailbox_select <= 1'h1;
    repeat (4) @(posedge clock);
    fifo_one_master_reset_n <= 1'h1;
    fifo_two_master_reset_n <= 1'h1;
    wait_on(1);
    wait_on(0);
    rx_port_mailbox_select <= 1'h0;
    lw_q = {};
    u_far.got = {};
    for (int i = 0; i < 5; i++)
      lw_q.push_back(36'h9a5b6c7d8 + i * 36'h1020304);
    foreach (lw_q[i]) begin
      lw_in_valid <= 1'h1;
      lw_in_data <= lw_q[i];
      wait_on(1);
    end
    lw_in_valid <= 1'h0;
    for (int n = 0; n < 90 && u_far.got.size() < 5 * np; n++)
      @(posedge clock);
    cmp(u_far.got.size(), 5 * np, "reads");
    if (u_far.got.size() < 5 * np)
      tally_and_finish();
    foreach (u_far.got[j])
      cmp(u_far.got[j] & (b ? 18'h1ff : 18'h3ffff),
          part(lw_q[j / np], j % np, b, e), "tx");
    foreach (lw_q[i]) for (int j = 0; j < np; j++) begin
      if (i == 1 && j == 1) begin
        put(18'h2b3c5, 1'h1);
        rx_write <= 1'h0;
        @(posedge clock);
        cmp({mail_valid, mail_data}, {1'h1, m}, "mail");
      end
      put(part(lw_q[i], j, b, e) | (b ? 18'h15a00 : 18'h0), 1'h0);
    end
    rx_write <= 1'h0;
    repeat (4) @(posedge clock);
    cmp(rx_ready, 1'h0, "full");
    lw_out_ready <= 1'h1;
    foreach (lw_q[i]) begin
      wait_on(2);
      cmp(lw_out_data, lw_q[i], "rx");
    end
    lw_out_ready <= 1'h0;
    // partial reset drops one written part, keeps lane order
    put(18'h3a1c7, 1'h0);
    rx_write <= 1'h0;
    fifo_two_partial_reset_n <= 1'h0;
    repeat (4) @(posedge clock);
    fifo_two_partial_reset_n <= 1'h1;
    wait_on(0);
    for (int j = 0; j < np; j++)
      put(part(lw_q[0], j, b, e), 1'h0);
    rx_write <= 1'h0;
    lw_out_ready <= 1'h1;
    wait_on(2);
    cmp(lw_out_data, lw_q[0], "partial");
    lw_out_ready <= 1'h0;
    $display("config byte %0d big %0d done", b, e);
  endtask

  // ==========================================
  // main sequence
  initial begin
    repeat (4) @(posedge clock);
    rstn <= 1'h1;
    for (int c = 0; c < 4; c++)
      run(c[1], c[0]);
    tally_and_finish();
  end
endmodule
